// >>> common/ifr_defs.svh
`ifndef IFR_DEFS_SVH
`define IFR_DEFS_SVH

// --------------------------------------------------------------
// register indices on the move-to / move-from path
// --------------------------------------------------------------
`define IFR_IDX_XLATE_TAG       12'h101
`define IFR_IDX_XLATE_PTE       12'h102
`define IFR_IDX_SPACE_ID        12'h103
`define IFR_IDX_PTE_HOLDING     12'h104
`define IFR_IDX_INV_ALL         12'h105
`define IFR_IDX_INV_PROCESS     12'h106
`define IFR_IDX_INV_SINGLE      12'h107
`define IFR_IDX_EXCEPTION_RESTART_ADDRESS        12'h10b
`define IFR_IDX_TRAP_SUMMARY    12'h10c
`define IFR_IDX_FAULT_FORM      12'h112
`define IFR_IDX_PT_BASE         12'h113
`define IFR_IDX_ICACHE_FLUSH    12'h119
`define IFR_IDX_ICACHE_ERR      12'h11a

// --------------------------------------------------------------
// translation buffer geometry and field positions
// --------------------------------------------------------------
`define IFR_ENTRIES             8
`define IFR_PTR_ZERO            3'h0
`define IFR_PTR_ONE             3'h1
`define IFR_VA_HI               42
`define IFR_VA_LO               13
`define IFR_ASN_HI              10
`define IFR_ASN_LO              4
`define IFR_PTE_GLOBAL          4
`define IFR_PTE_GH_HI           6
`define IFR_PTE_GH_LO           5
`define IFR_GHD_HI              31
`define IFR_GHD_LO              29
`define IFR_NT_VA_HI            31
`define IFR_PTB_HI              63
`define IFR_PTB_LO              30
`define IFR_PTB_NONNT_LO        33

// --------------------------------------------------------------
// status, address and summary fields
// --------------------------------------------------------------
`define IFR_ERR_DATA_BIT        11
`define IFR_ERR_TAG_BIT         12
`define IFR_ERR_TMO_BIT         13
`define IFR_EXC_PAL_BIT         0
`define IFR_SUM_SWC_BIT         10
`define IFR_SUM_CAUSE_LO        11
`define IFR_SUM_CAUSE_HI        16
`define IFR_WORD_ZERO           64'h0000_0000_0000_0000

`endif

// >>> common/ifr_pkg.sv
`default_nettype none

package ifr_pkg;
    typedef logic [63:0] ifr_word_type;
    typedef logic [29:0] ifr_vpn_type;
    typedef logic [6:0]  ifr_asn_type;
    typedef logic [2:0]  ifr_ptr_type;
    typedef logic [5:0]  ifr_cause_type;
    typedef logic [2:0]  ifr_err_type;
endpackage

`default_nettype wire

// >>> rtl/ifr_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "ifr_defs.svh"

module ifr_regs
    import ifr_pkg::*;
(
    input  wire logic          mclk_i,
    input  wire logic          reset_i,
    input  wire logic          ipr_write_i,
    input  wire logic          ipr_read_i,
    input  wire logic [11:0]   ipr_index_i,
    input  wire ifr_word_type  ipr_wdata_i,
    input  wire logic          istream_xlate_miss_i,
    input  wire logic          istream_access_violation_i,
    input  wire logic          sign_check_error_i,
    input  wire ifr_word_type  fault_va_i,
    input  wire logic          superpage_alternative_enable_i,
    input  wire logic          data_parity_error_i,
    input  wire logic          tag_parity_error_i,
    input  wire logic          timeout_error_i,
    input  wire logic          exc_precise_i,
    input  wire logic          exc_imprecise_i,
    input  wire ifr_word_type  fault_pc_i,
    input  wire ifr_word_type  next_issue_pc_i,
    input  wire logic          privileged_call_i,
    input  wire ifr_word_type  call_next_pc_i,
    input  wire logic          privileged_return_i,
    input  wire logic          arith_trap_i,
    input  wire logic          trap_sw_completion_i,
    input  wire ifr_cause_type trap_cause_i,
    output var  ifr_word_type  ipr_rdata_o,
    output var  logic          ipr_rvalid_o,
    output var  logic          icache_flush_o,
    output var  logic          return_valid_o,
    output var  ifr_word_type  return_pc_o,
    output var  logic          return_firmware_mode_o,
    output var  ifr_ptr_type   victim_pointer_o
);

    // --------------------------------------------------------------
    // state
    // --------------------------------------------------------------
    ifr_vpn_type   tag_hold_reg;
    ifr_asn_type   space_id_reg;
    ifr_word_type  pte_holding_reg;
    ifr_word_type  fault_form_reg;
    logic [`IFR_PTB_HI:`IFR_PTB_LO] pt_base_reg;
    ifr_err_type   icache_err_reg;
    ifr_word_type  exception_restart_address_reg;
    ifr_cause_type cause_reg;
    logic          swc_reg;
    logic          swc_blocked_reg;
    ifr_ptr_type   victim_ptr_reg;

    ifr_vpn_type   entry_tag_mem [`IFR_ENTRIES];
    ifr_word_type  entry_pte_mem [`IFR_ENTRIES];
    ifr_asn_type   entry_asn_mem [`IFR_ENTRIES];
    logic [`IFR_ENTRIES-1:0] entry_valid_reg;

    // --------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------
    function automatic logic is_write(input logic [11:0] idx);
        return ipr_write_i && (ipr_index_i == idx);
    endfunction

    function automatic logic is_read(input logic [11:0] idx);
        return ipr_read_i && (ipr_index_i == idx);
    endfunction

    function automatic logic [2:0] ghd_decode(input logic [1:0] gh);
        ghd_decode = {gh == 2'h3, gh[1], gh != 2'h0};
    endfunction

    logic wr_pte;
    logic rd_pte;
    logic fault_capture;
    logic [`IFR_PTE_GH_HI:`IFR_PTE_GH_LO] victim_gh;
    ifr_vpn_type  single_vpn;

    // decoded strobes shared by several processes
    assign wr_pte        = is_write(`IFR_IDX_XLATE_PTE);
    assign rd_pte        = is_read(`IFR_IDX_XLATE_PTE);
    assign fault_capture = (istream_xlate_miss_i || istream_access_violation_i);
    assign victim_gh     = entry_pte_mem[victim_ptr_reg][`IFR_PTE_GH_HI:`IFR_PTE_GH_LO];
    assign single_vpn    = ipr_wdata_i[`IFR_VA_HI:`IFR_VA_LO];

    // --------------------------------------------------------------
    // fault capture
    // --------------------------------------------------------------
    // tag holding register: hardware only, software cannot load it
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            tag_hold_reg <= '0;
        end else if (fault_capture) begin
            tag_hold_reg <= fault_va_i[`IFR_VA_HI:`IFR_VA_LO];
        end
    end

    // formatted address; sign-check violations leave the old value
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            fault_form_reg <= `IFR_WORD_ZERO;
        end else if (fault_capture && !sign_check_error_i) begin
            if (superpage_alternative_enable_i) begin
                fault_form_reg <= {pt_base_reg, 8'h00,
                                   fault_va_i[`IFR_NT_VA_HI:`IFR_VA_LO], 3'h0};
            end else begin
                fault_form_reg <= {pt_base_reg[`IFR_PTB_HI:`IFR_PTB_NONNT_LO],
                                   fault_va_i[`IFR_VA_HI:`IFR_VA_LO], 3'h0};
            end
        end
    end

    // --------------------------------------------------------------
    // translation entries and victim pointer
    // --------------------------------------------------------------
    // pointer has a reset value, but firmware still owes an invalidate-all
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            victim_ptr_reg <= `IFR_PTR_ZERO;
        end else if (is_write(`IFR_IDX_INV_ALL)) begin
            victim_ptr_reg <= `IFR_PTR_ZERO;
        end else if (wr_pte || rd_pte) begin
            victim_ptr_reg <= victim_ptr_reg + `IFR_PTR_ONE;
        end
    end

    // tag and entry land in one edge so no half-written slot is visible
    always_ff @(posedge mclk_i) begin
        if (wr_pte) begin
            entry_tag_mem[victim_ptr_reg] <= tag_hold_reg;
            entry_pte_mem[victim_ptr_reg] <= ipr_wdata_i;
            entry_asn_mem[victim_ptr_reg] <= space_id_reg;
        end
    end

    // valid bits: one maintenance operation per instruction
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            entry_valid_reg <= '0;
        end else if (is_write(`IFR_IDX_INV_ALL)) begin
            entry_valid_reg <= '0;
        end else if (is_write(`IFR_IDX_INV_PROCESS)) begin
            for (int i = 0; i < `IFR_ENTRIES; i++) begin
                if (!entry_pte_mem[i][`IFR_PTE_GLOBAL]) begin
                    entry_valid_reg[i] <= 1'b0;
                end
            end
        end else if (is_write(`IFR_IDX_INV_SINGLE)) begin
            for (int i = 0; i < `IFR_ENTRIES; i++) begin
                if (entry_tag_mem[i] == single_vpn &&
                    (entry_asn_mem[i] == space_id_reg ||
                     entry_pte_mem[i][`IFR_PTE_GLOBAL])) begin
                    entry_valid_reg[i] <= 1'b0;
                end
            end
        end else if (wr_pte) begin
            entry_valid_reg[victim_ptr_reg] <= 1'b1;
        end
    end

    // read of the entry is a side effect; the holding register carries it
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            pte_holding_reg <= `IFR_WORD_ZERO;
        end else if (rd_pte) begin
            pte_holding_reg <= entry_pte_mem[victim_ptr_reg];
            pte_holding_reg[`IFR_GHD_HI:`IFR_GHD_LO] <= ghd_decode(victim_gh);
        end
    end

    // --------------------------------------------------------------
    // software-loaded control registers
    // --------------------------------------------------------------
    // current space identifier steers single invalidate and new entries
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            space_id_reg <= '0;
        end else if (is_write(`IFR_IDX_SPACE_ID)) begin
            space_id_reg <= ipr_wdata_i[`IFR_ASN_HI:`IFR_ASN_LO];
        end
    end

    // full base kept; normal mode simply ignores the low three bits
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            pt_base_reg <= '0;
        end else if (is_write(`IFR_IDX_PT_BASE)) begin
            pt_base_reg <= ipr_wdata_i[`IFR_PTB_HI:`IFR_PTB_LO];
        end
    end

    // --------------------------------------------------------------
    // icache status and flush
    // --------------------------------------------------------------
    // set wins over a write-one clear in the same cycle
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            icache_err_reg <= '0;
        end else begin
            icache_err_reg <= (icache_err_reg &
                ~({3{is_write(`IFR_IDX_ICACHE_ERR)}} &
                  ipr_wdata_i[`IFR_ERR_TMO_BIT:`IFR_ERR_DATA_BIT]))
                | {timeout_error_i, tag_parity_error_i, data_parity_error_i};
        end
    end

    // data value is ignored; the write itself is the command
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            icache_flush_o <= 1'b0;
        end else begin
            icache_flush_o <= is_write(`IFR_IDX_ICACHE_FLUSH);
        end
    end

    // --------------------------------------------------------------
    // exception address and return
    // --------------------------------------------------------------
    // priority: exception, then call, then software
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            exception_restart_address_reg <= `IFR_WORD_ZERO;
        end else if (exc_precise_i) begin
            exception_restart_address_reg <= fault_pc_i;
        end else if (exc_imprecise_i) begin
            exception_restart_address_reg <= next_issue_pc_i;
        end else if (privileged_call_i) begin
            exception_restart_address_reg <= call_next_pc_i;
        end else if (is_write(`IFR_IDX_EXCEPTION_RESTART_ADDRESS)) begin
            exception_restart_address_reg <= ipr_wdata_i;
        end
    end

    // return target handed to fetch one edge after the request
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            return_valid_o         <= 1'b0;
            return_pc_o            <= `IFR_WORD_ZERO;
            return_firmware_mode_o <= 1'b0;
        end else begin
            return_valid_o <= privileged_return_i;
            if (privileged_return_i) begin
                return_pc_o            <= exception_restart_address_reg;
                return_firmware_mode_o <= exception_restart_address_reg[`IFR_EXC_PAL_BIT];
            end
        end
    end

    // --------------------------------------------------------------
    // arithmetic trap summary
    // --------------------------------------------------------------
    // a trap in the same cycle as the clearing write is kept
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            cause_reg <= '0;
        end else begin
            cause_reg <= (is_write(`IFR_IDX_TRAP_SUMMARY) ? '0 : cause_reg)
                         | ({6{arith_trap_i}} & trap_cause_i);
        end
    end

    // blocked remembers an unqualified trap until software rewrites
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            swc_reg         <= 1'b0;
            swc_blocked_reg <= 1'b0;
        end else begin
            if (is_write(`IFR_IDX_TRAP_SUMMARY)) begin
                swc_reg         <= arith_trap_i && trap_sw_completion_i;
                swc_blocked_reg <= arith_trap_i && !trap_sw_completion_i;
            end else if (arith_trap_i && !trap_sw_completion_i) begin
                swc_reg         <= 1'b0;
                swc_blocked_reg <= 1'b1;
            end else if (arith_trap_i && !swc_blocked_reg) begin
                swc_reg <= 1'b1;
            end
        end
    end

    // --------------------------------------------------------------
    // read path
    // --------------------------------------------------------------
    // answer one edge after the read; write-only indices read as zero
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            ipr_rdata_o  <= `IFR_WORD_ZERO;
            ipr_rvalid_o <= 1'b0;
        end else begin
            ipr_rvalid_o <= ipr_read_i;
            ipr_rdata_o  <= `IFR_WORD_ZERO;
            if (ipr_read_i) begin
                unique case (ipr_index_i)
                    `IFR_IDX_SPACE_ID: begin
                        ipr_rdata_o[`IFR_ASN_HI:`IFR_ASN_LO] <= space_id_reg;
                    end
                    `IFR_IDX_PTE_HOLDING: begin
                        ipr_rdata_o <= pte_holding_reg;
                    end
                    `IFR_IDX_FAULT_FORM: begin
                        ipr_rdata_o <= fault_form_reg;
                    end
                    `IFR_IDX_PT_BASE: begin
                        // low bits forced to zero in normal mode
                        ipr_rdata_o[`IFR_PTB_HI:`IFR_PTB_LO] <= superpage_alternative_enable_i
                            ? pt_base_reg : {pt_base_reg[`IFR_PTB_HI:`IFR_PTB_NONNT_LO], 3'h0};
                    end
                    `IFR_IDX_ICACHE_ERR: begin
                        ipr_rdata_o[`IFR_ERR_TMO_BIT:`IFR_ERR_DATA_BIT] <= icache_err_reg;
                    end
                    `IFR_IDX_EXCEPTION_RESTART_ADDRESS: begin
                        ipr_rdata_o <= exception_restart_address_reg;
                    end
                    `IFR_IDX_TRAP_SUMMARY: begin
                        ipr_rdata_o[`IFR_SUM_CAUSE_HI:`IFR_SUM_SWC_BIT] <= {cause_reg, swc_reg};
                    end
                    default: begin
                        ipr_rdata_o <= `IFR_WORD_ZERO;
                    end
                endcase
            end
        end
    end

    assign victim_pointer_o = victim_ptr_reg;

    // --------------------------------------------------------------
    // assertions
    // --------------------------------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (reset_i);

    chk_tag_capture: assert property (fault_capture |=>
        tag_hold_reg == $past(fault_va_i[`IFR_VA_HI:`IFR_VA_LO]))
        else $error("tag holding register missed fault");
    chk_pte_write_slot: assert property (wr_pte |=>
        entry_valid_reg[$past(victim_ptr_reg)] &&
        entry_pte_mem[$past(victim_ptr_reg)] == $past(ipr_wdata_i) &&
        entry_tag_mem[$past(victim_ptr_reg)] == $past(tag_hold_reg))
        else $error("page entry write did not fill victim slot");
    chk_ptr_advance: assert property (wr_pte |=>
        victim_ptr_reg == $past(victim_ptr_reg) + `IFR_PTR_ONE)
        else $error("victim pointer did not advance on write");
    chk_pte_read_zero: assert property (rd_pte |=>
        ipr_rvalid_o && ipr_rdata_o == `IFR_WORD_ZERO &&
        victim_ptr_reg == $past(victim_ptr_reg) + `IFR_PTR_ONE)
        else $error("page entry read wrong");
    chk_holding_return: assert property (is_read(`IFR_IDX_PTE_HOLDING) |=>
        ipr_rvalid_o && ipr_rdata_o == $past(pte_holding_reg))
        else $error("holding register read wrong");
    chk_ghd_thermo: assert property ((!pte_holding_reg[31] || pte_holding_reg[30]) &&
        (!pte_holding_reg[30] || pte_holding_reg[29]))
        else $error("granularity bits not thermometer coded");
    chk_inv_all: assert property (is_write(`IFR_IDX_INV_ALL) |=>
        victim_ptr_reg == `IFR_PTR_ZERO && entry_valid_reg == '0)
        else $error("invalidate-all incomplete");
    chk_err_sticky: assert property (data_parity_error_i ##1 !is_write(`IFR_IDX_ICACHE_ERR)
        |=> icache_err_reg[0])
        else $error("data parity flag lost");
    chk_flush_pulse: assert property (is_write(`IFR_IDX_ICACHE_FLUSH) |=> icache_flush_o)
        else $error("flush not issued");
    chk_exc_wins: assert property (exc_precise_i |=> exception_restart_address_reg == $past(fault_pc_i))
        else $error("exception address not captured");
    chk_sum_clear: assert property (is_write(`IFR_IDX_TRAP_SUMMARY) && !arith_trap_i
        |=> cause_reg == '0 && !swc_reg)
        else $error("summary write did not clear");
    chk_swc_blocked: assert property (arith_trap_i && !trap_sw_completion_i
        |=> !swc_reg ##1 (!swc_reg || $past(is_write(`IFR_IDX_TRAP_SUMMARY))))
        else $error("completion flag set after unqualified trap");

    cov_write_then_read: cover property (wr_pte ##[1:8] rd_pte ##1
        is_read(`IFR_IDX_PTE_HOLDING));
    cov_single_inv: cover property (is_write(`IFR_IDX_INV_SINGLE));
    cov_swc_set: cover property (arith_trap_i && trap_sw_completion_i ##1 swc_reg);
    cov_exc_vs_write: cover property (exc_imprecise_i && is_write(`IFR_IDX_EXCEPTION_RESTART_ADDRESS));

endmodule

`default_nettype wire

// >>> verif/tb_ifr_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "ifr_defs.svh"
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin num_errors++; \
    $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end

module tb_ifr_regs
    import ifr_pkg::*;
;
    // ------------------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------------------
    logic          mclk_i, reset_i, ipr_write_i, ipr_read_i, istream_xlate_miss_i;
    logic          istream_access_violation_i, sign_check_error_i, superpage_alternative_enable_i;
    logic          data_parity_error_i, tag_parity_error_i, timeout_error_i, exc_precise_i;
    logic          exc_imprecise_i, privileged_call_i, privileged_return_i, arith_trap_i;
    logic          trap_sw_completion_i, ipr_rvalid_o, icache_flush_o, return_valid_o;
    logic          return_firmware_mode_o;
    logic [11:0]   ipr_index_i;
    ifr_cause_type trap_cause_i;
    ifr_ptr_type   victim_pointer_o;
    ifr_word_type  ipr_wdata_i, fault_va_i, fault_pc_i, next_issue_pc_i, call_next_pc_i;
    ifr_word_type  ipr_rdata_o, return_pc_o, base, va, w, acc, note;
    ifr_word_type  exp_q[$];
    ifr_word_type  pte[8];
    int            num_errors   = 0;
    int            total_checks = 0;
    integer        seed         = 32'h03b4;

    ifr_regs u_ifr_regs (.mclk_i, .reset_i, .ipr_write_i, .ipr_read_i, .ipr_index_i,
        .ipr_wdata_i, .istream_xlate_miss_i, .istream_access_violation_i, .sign_check_error_i,
        .fault_va_i, .superpage_alternative_enable_i, .data_parity_error_i, .tag_parity_error_i,
        .timeout_error_i, .exc_precise_i, .exc_imprecise_i, .fault_pc_i, .next_issue_pc_i,
        .privileged_call_i, .call_next_pc_i, .privileged_return_i, .arith_trap_i,
        .trap_sw_completion_i, .trap_cause_i, .ipr_rdata_o, .ipr_rvalid_o, .icache_flush_o,
        .return_valid_o, .return_pc_o, .return_firmware_mode_o, .victim_pointer_o);

    // 200 MHz core clock
    always #2.5 mclk_i = ~mclk_i;

    // ------------------------------------------------------------
    // bus and event drivers, all launched on the falling edge
    // ------------------------------------------------------------
    // one spare cycle between ops so no strobe is assigned twice in a step
    task automatic op(input logic wr, input logic [11:0] idx, input ifr_word_type d,
                      input ifr_word_type e);
        @(negedge mclk_i);
        ipr_write_i = wr;
        ipr_read_i  = !wr;
        ipr_index_i = idx;
        ipr_wdata_i = d;
        if (!wr) exp_q.push_back(e);
        @(negedge mclk_i);
        ipr_write_i = 1'b0;
        ipr_read_i  = 1'b0;
    endtask

    task automatic pulse(ref logic s);
        @(negedge mclk_i);
        s = 1'b1;
        @(negedge mclk_i);
        s = 1'b0;
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // read data stands one cycle; oldest note is matched against it
    always @(negedge mclk_i) begin
        if (ipr_rvalid_o === 1'b1) begin
            if (exp_q.size() == 0) `CHK(1'b1, 1'b0)
            else begin
                // pop once: the macro names its arguments twice
                note = exp_q.pop_front();
                `CHK(ipr_rdata_o, note)
            end
        end
    end

    // hang guard, far beyond the fewer than two hundred cycles the tests need
    initial begin
        #50000;
        num_errors++;
        wrap_up();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {mclk_i, ipr_write_i, ipr_read_i, ipr_index_i, ipr_wdata_i, fault_va_i} = '0;
        {istream_xlate_miss_i, istream_access_violation_i, sign_check_error_i} = '0;
        {superpage_alternative_enable_i, data_parity_error_i, tag_parity_error_i} = '0;
        {timeout_error_i, exc_precise_i, exc_imprecise_i, fault_pc_i, next_issue_pc_i} = '0;
        {privileged_call_i, call_next_pc_i, privileged_return_i, arith_trap_i} = '0;
        {trap_sw_completion_i, trap_cause_i} = '0;
        reset_i = 1'b1;
        repeat (20) @(posedge mclk_i);
        @(negedge mclk_i) reset_i = 1'b0;
        op(1'b1, `IFR_IDX_INV_ALL, '0, '0);
        `CHK(victim_pointer_o, 3'h0)
        fault_va_i = {$random(seed), $random(seed)};
        pulse(istream_xlate_miss_i);
        // fill every slot with each granularity hint, pointer wraps to zero
        for (int i = 0; i < 8; i++) begin
            pte[i] = {$random(seed), $random(seed)};
            pte[i][6:5] = i[1:0];
            op(1'b1, `IFR_IDX_XLATE_PTE, pte[i], '0);
            `CHK(victim_pointer_o, 3'(i + 1))
        end
        for (int i = 0; i < 8; i++) begin
            w = pte[i];
            w[31:29] = {w[6] & w[5], w[6], w[6] | w[5]};
            op(1'b0, `IFR_IDX_XLATE_PTE, '0, '0);
            `CHK(victim_pointer_o, 3'(i + 1))
            op(1'b0, `IFR_IDX_PTE_HOLDING, '0, w);
        end
        op(1'b1, `IFR_IDX_XLATE_PTE, pte[0], '0);
        op(1'b1, `IFR_IDX_INV_ALL, '0, '0);
        `CHK(victim_pointer_o, 3'h0)
        $display("test translation entries done");
        // formatted fault address in both modes, sign errors leave it alone
        base = {$random(seed), $random(seed)};
        va = {$random(seed), $random(seed)};
        fault_va_i = va;
        op(1'b1, `IFR_IDX_PT_BASE, base, '0);
        pulse(istream_access_violation_i);
        op(1'b0, `IFR_IDX_FAULT_FORM, '0, {base[63:33], va[42:13], 3'h0});
        fault_va_i = ~va;
        sign_check_error_i = 1'b1;
        pulse(istream_access_violation_i);
        sign_check_error_i = 1'b0;
        op(1'b0, `IFR_IDX_FAULT_FORM, '0, {base[63:33], va[42:13], 3'h0});
        superpage_alternative_enable_i = 1'b1;
        pulse(istream_xlate_miss_i);
        op(1'b0, `IFR_IDX_FAULT_FORM, '0, {base[63:30], 8'h00, ~va[31:13], 3'h0});
        op(1'b0, `IFR_IDX_PT_BASE, '0, {base[63:30], 30'h0});
        superpage_alternative_enable_i = 1'b0;
        $display("test fault address done");
        // sticky icache error flags and flush pulse
        pulse(data_parity_error_i);
        pulse(tag_parity_error_i);
        pulse(timeout_error_i);
        op(1'b0, `IFR_IDX_ICACHE_ERR, '0, 64'h0000_0000_0000_3800);
        op(1'b1, `IFR_IDX_ICACHE_ERR, 64'h0000_0000_0000_1000, '0);
        op(1'b0, `IFR_IDX_ICACHE_ERR, '0, 64'h0000_0000_0000_2800);
        op(1'b1, `IFR_IDX_ICACHE_FLUSH, {$random(seed), $random(seed)}, '0);
        `CHK(icache_flush_o, 1'b1)
        @(negedge mclk_i) `CHK(icache_flush_o, 1'b0)
        $display("test icache done");
        // hardware save collides with a software write and must win
        w = {$random(seed), $random(seed)};
        fault_pc_i = w;
        @(negedge mclk_i);
        {exc_precise_i, ipr_write_i, ipr_index_i, ipr_wdata_i} = {2'b11, `IFR_IDX_EXCEPTION_RESTART_ADDRESS, ~w};
        @(negedge mclk_i);
        {exc_precise_i, ipr_write_i} = 2'b00;
        op(1'b0, `IFR_IDX_EXCEPTION_RESTART_ADDRESS, '0, w);
        next_issue_pc_i = ~w;
        pulse(exc_imprecise_i);
        op(1'b0, `IFR_IDX_EXCEPTION_RESTART_ADDRESS, '0, ~w);
        for (int m = 0; m < 2; m++) begin
            call_next_pc_i = {w[63:1], m[0]};
            pulse(privileged_call_i);
            op(1'b0, `IFR_IDX_EXCEPTION_RESTART_ADDRESS, '0, call_next_pc_i);
            pulse(privileged_return_i);
            `CHK({return_valid_o, return_pc_o}, {1'b1, call_next_pc_i})
            `CHK(return_firmware_mode_o, m[0])
        end
        $display("test restart address done");
        // every cause bit accumulates while completion stays possible
        acc = 64'h0000_0000_0000_0400;
        for (int k = 0; k < 6; k++) begin
            {trap_sw_completion_i, trap_cause_i} = {1'b1, 6'(1 << k)};
            pulse(arith_trap_i);
            acc[11 + k] = 1'b1;
            op(1'b0, `IFR_IDX_TRAP_SUMMARY, '0, acc);
        end
        acc[10] = 1'b0;
        for (int q = 0; q < 2; q++) begin
            {trap_sw_completion_i, trap_cause_i} = {q[0], 6'h01};
            pulse(arith_trap_i);
            op(1'b0, `IFR_IDX_TRAP_SUMMARY, '0, acc);
        end
        op(1'b1, `IFR_IDX_TRAP_SUMMARY, {$random(seed), $random(seed)}, '0);
        op(1'b0, `IFR_IDX_TRAP_SUMMARY, '0, '0);
        {trap_sw_completion_i, trap_cause_i} = {1'b1, 6'h02};
        pulse(arith_trap_i);
        op(1'b0, `IFR_IDX_TRAP_SUMMARY, '0, 64'h0000_0000_0000_1400);
        $display("test trap summary done");
        repeat (4) @(negedge mclk_i);
        `CHK(exp_q.size(), 0)
        wrap_up();
    end
endmodule

`undef CHK
`default_nettype wire
